/* shared/lidg_defs.svh */
// constants for the load decode and address generation block
`ifndef LIDG_DEFS_SVH
`define LIDG_DEFS_SVH

// opcode patterns, instruction bits 15:11 or 15:9
`define LIDG_OP5_LIT 5'h09
`define LIDG_OP5_BYTE_IMM 5'h0F
`define LIDG_OP5_HALF_IMM 5'h11
`define LIDG_OP7_WORD_REG 7'h2C
`define LIDG_OP7_BYTE_REG 7'h2E
// pc alignment mask, clears the low two bits
`define LIDG_PC_ALIGN_MASK 32'hFFFFFFFC
`define LIDG_RESET_WORD 32'h00000000

`endif

/* shared/lidg_pkg.sv */
// types for the load decode and address generation block
package lidg_pkg;

	typedef enum logic [1:0] {
		LIDG_SIZE_BYTE = 2'h0,
		LIDG_SIZE_HALF = 2'h1,
		LIDG_SIZE_WORD = 2'h2
	} lidg_size_t;

	typedef enum logic [3:0] {
		LIDG_K_NONE = 4'h0,
		LIDG_K_LIT = 4'h1,
		LIDG_K_WORD_REG = 4'h2,
		LIDG_K_BYTE_IMM = 4'h3,
		LIDG_K_BYTE_REG = 4'h4,
		LIDG_K_HALF_IMM = 4'h5
	} lidg_kind_t;

	typedef enum logic [2:0] {
		LIDG_ST_IDLE = 3'b001,
		LIDG_ST_REQ = 3'b010,
		LIDG_ST_WAIT = 3'b100
	} lidg_state_t;

endpackage

/* hdl/lidg_decode.sv */
// instruction field extraction and effective address for the load group
`timescale 1ns/100ps
`default_nettype none
`include "lidg_defs.svh"

module lidg_decode (
	input wire logic [15:0] insn,
	input wire logic [31:0] pc,
	input wire logic [31:0] base_val,
	input wire logic [31:0] offset_val,
	output lidg_pkg::lidg_kind_t kind,
	output logic [2:0] dest_reg_field,
	output logic [2:0] base_reg_field,
	output logic [2:0] offset_reg_field,
	output logic [31:0] eff_addr,
	output lidg_pkg::lidg_size_t size
);

	logic [4:0] short_imm_field;
	logic [7:0] long_imm_field;

	always_comb begin
		short_imm_field = insn[10:6];
		long_imm_field = insn[7:0];
		offset_reg_field = insn[8:6]; // RL3
		base_reg_field = insn[5:3]; // RL3
		dest_reg_field = insn[2:0]; // RL3
		kind = lidg_pkg::LIDG_K_NONE;
		size = lidg_pkg::LIDG_SIZE_WORD;
		eff_addr = `LIDG_RESET_WORD;
		if (insn[15:11] == `LIDG_OP5_LIT) begin
			kind = lidg_pkg::LIDG_K_LIT;
			dest_reg_field = insn[10:8];
			// aligned pc plus imm with two zero bits appended
			eff_addr = (pc & `LIDG_PC_ALIGN_MASK)
				+ {22'h0, long_imm_field, 2'h0}; // RL1 RL2
		end else if (insn[15:9] == `LIDG_OP7_WORD_REG) begin // RL3
			kind = lidg_pkg::LIDG_K_WORD_REG;
			eff_addr = base_val + offset_val; // RL4 RL12
		end else if (insn[15:9] == `LIDG_OP7_BYTE_REG) begin // RL7
			kind = lidg_pkg::LIDG_K_BYTE_REG;
			size = lidg_pkg::LIDG_SIZE_BYTE;
			eff_addr = base_val + offset_val; // RL4 RL7
		end else if (insn[15:11] == `LIDG_OP5_BYTE_IMM) begin
			kind = lidg_pkg::LIDG_K_BYTE_IMM;
			size = lidg_pkg::LIDG_SIZE_BYTE;
			// zero imm gives the base itself
			eff_addr = base_val + {27'h0, short_imm_field}; // RL5 RL11
		end else if (insn[15:11] == `LIDG_OP5_HALF_IMM) begin
			kind = lidg_pkg::LIDG_K_HALF_IMM;
			size = lidg_pkg::LIDG_SIZE_HALF;
			eff_addr = base_val
				+ {26'h0, short_imm_field, 1'h0}; // RL8 RL11
		end
	end

endmodule
`default_nettype wire

/* hdl/lidg_load_unit.sv */
// load group decode, address generation, memory read and writeback
//
// Contract
// (RL1) The literal load reads a word at the pc rounded down to four plus the offset and writes it to the destination.
// (RL2) The literal offset is the 8-bit immediate with two zero bits appended, zero-extended.
// (RL3) The register-offset word load matches bits 15:9 = 0101100 with offset, base and destination in 8:6, 5:3, 2:0.
// (RL4) Register-offset loads address base plus unshifted offset register.
// (RL5) The byte immediate load adds the unscaled zero-extended 5-bit immediate to the base.
// (RL6) Both byte loads read one byte and write it zero-extended.
// (RL7) The register-offset byte load addresses base plus offset register and differs only in opcode.
// (RL8) The halfword immediate offset is the 5-bit immediate with one zero bit appended.
// (RL9) The halfword load reads two bytes and writes them zero-extended.
// (RL10) No load writes the computed address back to the base register.
// (RL11) An absent immediate means offset zero, so the address is the base.
// (RL12) The register-offset word load writes the full word unchanged.
// (RL13) Writeback waits for read data and every read carries a size code.
// (RL14) Memory returns the data right-justified in the low bits.
`timescale 1ns/100ps
`default_nettype none
`include "lidg_defs.svh"

module lidg_load_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic insn_valid,
	output logic insn_ready,
	input wire logic [15:0] insn,
	input wire logic [31:0] pc,
	output logic [2:0] base_reg_field,
	output logic [2:0] offset_reg_field,
	input wire logic [31:0] base_val,
	input wire logic [31:0] offset_val,
	output logic insn_illegal,
	output logic mem_req,
	input wire logic mem_ack,
	output logic [31:0] mem_addr,
	output lidg_pkg::lidg_size_t mem_size,
	input wire logic mem_rvalid,
	input wire logic [31:0] mem_rdata,
	output logic wb_en,
	output logic [2:0] wb_reg,
	output logic [31:0] wb_data
);

	////////////////////////////////////////////////////////////////////////
	lidg_pkg::lidg_kind_t dec_kind;
	logic [2:0] dec_dest;
	logic [31:0] dec_addr;
	lidg_pkg::lidg_size_t dec_size;

	lidg_decode u_decode (
		.insn(insn),
		.pc(pc),
		.base_val(base_val),
		.offset_val(offset_val),
		.kind(dec_kind),
		.dest_reg_field(dec_dest),
		.base_reg_field(base_reg_field),
		.offset_reg_field(offset_reg_field),
		.eff_addr(dec_addr),
		.size(dec_size)
	);

	function automatic logic [31:0] lidg_zext(
		input lidg_pkg::lidg_size_t sz,
		input logic [31:0] d
	);
		case (sz)
			lidg_pkg::LIDG_SIZE_BYTE: lidg_zext = {24'h000000, d[7:0]};
			lidg_pkg::LIDG_SIZE_HALF: lidg_zext = {16'h0000, d[15:0]};
			default: lidg_zext = d;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	lidg_pkg::lidg_state_t state_reg, state_next;
	logic [31:0] addr_reg, addr_next;
	lidg_pkg::lidg_size_t size_reg, size_next;
	logic [2:0] dest_reg, dest_next;
	logic wb_en_reg, wb_en_next;
	logic [31:0] wb_data_reg, wb_data_next;
	logic illegal_reg, illegal_next;

	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		size_next = size_reg;
		dest_next = dest_reg;
		wb_en_next = 1'b0;
		wb_data_next = wb_data_reg;
		illegal_next = 1'b0;
		case (state_reg)
			lidg_pkg::LIDG_ST_IDLE: begin
				if (insn_valid) begin
					if (dec_kind == lidg_pkg::LIDG_K_NONE) begin
						illegal_next = 1'b1;
					end else begin
						// address, size and destination are kept: base never updated
						addr_next = dec_addr; // RL10
						size_next = dec_size; // RL13
						dest_next = dec_dest;
						state_next = lidg_pkg::LIDG_ST_REQ;
					end
				end
			end
			lidg_pkg::LIDG_ST_REQ: begin
				if (mem_ack) begin
					state_next = lidg_pkg::LIDG_ST_WAIT;
				end
			end
			lidg_pkg::LIDG_ST_WAIT: begin
				// hold writeback until data arrives
				if (mem_rvalid) begin // RL13
					wb_en_next = 1'b1;
					// relies on right-justified read data
					wb_data_next = lidg_zext(size_reg, mem_rdata); // RL6 RL9 RL12 RL14
					state_next = lidg_pkg::LIDG_ST_IDLE;
				end
			end
			default: begin
				state_next = lidg_pkg::LIDG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= lidg_pkg::LIDG_ST_IDLE;
			addr_reg <= `LIDG_RESET_WORD;
			size_reg <= lidg_pkg::LIDG_SIZE_WORD;
			dest_reg <= 3'h0;
			wb_en_reg <= 1'b0;
			wb_data_reg <= `LIDG_RESET_WORD;
			illegal_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			size_reg <= size_next;
			dest_reg <= dest_next;
			wb_en_reg <= wb_en_next;
			wb_data_reg <= wb_data_next;
			illegal_reg <= illegal_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign insn_ready = (state_reg == lidg_pkg::LIDG_ST_IDLE);
	assign mem_req = (state_reg == lidg_pkg::LIDG_ST_REQ);
	assign mem_addr = addr_reg;
	assign mem_size = size_reg;
	assign wb_en = wb_en_reg;
	assign wb_reg = dest_reg;
	assign wb_data = wb_data_reg;
	assign insn_illegal = illegal_reg;

endmodule
`default_nettype wire

/* test/lidg_load_unit_props.sv */
// concurrent checks on the load unit ports
`timescale 1ns/100ps
`default_nettype none
module lidg_load_unit_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic insn_valid,
	input wire logic insn_ready,
	input wire logic [15:0] insn,
	input wire logic [31:0] pc,
	input wire logic [31:0] base_val,
	input wire logic [31:0] offset_val,
	input wire logic [2:0] base_reg_field,
	input wire logic [2:0] offset_reg_field,
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic [31:0] mem_addr,
	input wire lidg_pkg::lidg_size_t mem_size,
	input wire logic wb_en
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
logic acc;
assign acc = insn_valid && insn_ready;
////////////////////////////////////////
a_lit_addr: assert property (acc && insn[15:11] == 5'h09 |=>
	mem_size == lidg_pkg::LIDG_SIZE_WORD && mem_addr ==
	($past(pc) & 32'hFFFFFFFC) + {22'h0, $past(insn[7:0]), 2'h0})
	else $error("literal load address wrong");
a_word_reg: assert property (acc && insn[15:9] == 7'h2C |=>
	mem_size == lidg_pkg::LIDG_SIZE_WORD &&
	mem_addr == $past(base_val) + $past(offset_val))
	else $error("word register load address wrong");
a_byte_imm: assert property (acc && insn[15:11] == 5'h0F |=>
	mem_size == lidg_pkg::LIDG_SIZE_BYTE &&
	mem_addr == $past(base_val) + {27'h0, $past(insn[10:6])})
	else $error("byte immediate address wrong");
a_byte_reg: assert property (acc && insn[15:9] == 7'h2E |=>
	mem_size == lidg_pkg::LIDG_SIZE_BYTE &&
	mem_addr == $past(base_val) + $past(offset_val))
	else $error("byte register address wrong");
a_half_imm: assert property (acc && insn[15:11] == 5'h11 |=>
	mem_size == lidg_pkg::LIDG_SIZE_HALF &&
	mem_addr == $past(base_val) + {26'h0, $past(insn[10:6]), 1'h0})
	else $error("halfword address wrong");
a_base_idx: assert property (base_reg_field == insn[5:3])
	else $error("base index field wrong");
a_off_idx: assert property (offset_reg_field == insn[8:6])
	else $error("offset index field wrong");
a_req_hold: assert property (mem_req && !mem_ack |=>
	mem_req && $stable(mem_addr) && $stable(mem_size))
	else $error("request dropped before ack");
a_wb_waits: assert property (acc && insn[15:11] == 5'h09 |=>
	!wb_en [*2]) else $error("writeback before read data");
c_wb: cover property (wb_en);
c_stall: cover property (mem_req && !mem_ack);
c_busy: cover property (insn_valid && !insn_ready);
endmodule
`default_nettype wire

/* test/lidg_mem_model.sv */
// data memory stand-in with random ack and data latency
`timescale 1ns/100ps
`default_nettype none
module lidg_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic mem_rvalid,
	output logic [31:0] mem_rdata
);
int s = 63382;
logic pend;
logic [1:0] dly;
logic [31:0] d;
always @(posedge clk or posedge rst)
	if (rst) begin
		{mem_ack, mem_rvalid, pend, dly, mem_rdata, d} <= '0;
	end else begin
		mem_ack <= 1'b0;
		mem_rvalid <= 1'b0;
		// noise while idle, never a stale word
		mem_rdata <= $random(s);
		if (mem_req && mem_ack) begin
			pend <= 1'b1;
			d <= ~mem_addr ^ 32'h5A5A5A5A;
			dly <= 2'($random(s));
		end else if ((mem_req || pend) && dly != 2'h0) begin
			dly <= dly - 2'h1;
		end else if (mem_req) begin
			mem_ack <= 1'b1;
		end else if (pend) begin
			pend <= 1'b0;
			mem_rvalid <= 1'b1;
			mem_rdata <= d;
			dly <= 2'($random(s));
		end
	end
endmodule
`default_nettype wire

/* test/lidg_load_unit_bench.sv */
// self-checking bench for the load unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
$display("MISMATCH t=%0t %h %h", $time, a, e); end end
module lidg_load_unit_bench;
logic clk = 0, rst = 1, insn_valid = 0, insn_ready, insn_illegal;
logic mem_req, mem_ack, mem_rvalid, wb_en;
logic [15:0] insn = 16'h0000;
logic [31:0] pc = 32'h0, base_val = 32'h0, offset_val = 32'h0;
logic [31:0] mem_addr, mem_rdata, wb_data;
logic [2:0] base_reg_field, offset_reg_field, wb_reg;
lidg_pkg::lidg_size_t mem_size;
int seed = 63382, fails = 0, check_count = 0, cyc = 0;
initial forever #4 clk = ~clk;
lidg_load_unit dut (.*);
lidg_mem_model mdl (.*);
task end_sim;
	$display("checks %0d fails %0d", check_count, fails);
	if (fails == 0 && check_count > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
always @(posedge clk) begin
	cyc++;
	if (cyc == 20000) begin fails++; end_sim; end
end
////////////////////////////////////////
task automatic load(int k, logic [15:0] r);
	logic [15:0] i;
	logic [31:0] a, d, x;
	logic [1:0] es;
	i = k == 0 ? {5'h09, r[10:0]} : k == 1 ? {7'h2C, r[8:0]} :
		k == 2 ? {5'h0F, r[10:0]} : k == 3 ? {7'h2E, r[8:0]} :
		k == 4 ? {5'h11, r[10:0]} : {5'h1F, r[10:0]};
	@(posedge clk);
	insn_valid <= 1'b1;
	insn <= i;
	pc <= $random(seed);
	base_val <= $random(seed);
	offset_val <= $random(seed);
	@(posedge clk) insn_valid <= 1'b0;
	#1;
	a = k == 0 ? (pc & 32'hFFFFFFFC) + {22'h0, i[7:0], 2'h0} :
		k == 2 ? base_val + {27'h0, i[10:6]} :
		k == 4 ? base_val + {26'h0, i[10:6], 1'h0} : base_val + offset_val;
	es = k == 4 ? 2'h1 : (k == 2 || k == 3) ? 2'h0 : 2'h2;
	if (k == 5) begin
		`CHK(insn_illegal, 1'b1)
		return;
	end
	`CHK(mem_req, 1'b1)
	`CHK(insn_ready, 1'b0)
	`CHK(mem_addr, a)
	`CHK(mem_size, es)
	d = ~a ^ 32'h5A5A5A5A;
	x = es == 2'h0 ? {24'h0, d[7:0]} : es == 2'h1 ? {16'h0, d[15:0]} : d;
	while (wb_en !== 1'b1) @(posedge clk) #1;
	`CHK(wb_data, x)
	`CHK(insn_ready, 1'b1)
	`CHK(wb_reg, k == 0 ? i[10:8] : i[2:0])
endtask
initial begin
	repeat (5) @(posedge clk);
	rst <= 1'b0;
	// zero and top immediates, random pc
	for (int k = 0; k < 6; k++) begin
		load(k, 16'h0000);
		load(k, 16'hFFFF);
	end
	repeat (80) load($unsigned($random(seed)) % 6, 16'($random(seed)));
	end_sim;
end
endmodule
bind lidg_load_unit lidg_load_unit_props chk (.*);
`default_nettype wire
